// >>> core/dacif_regs.svh
// Purpose: Constants for the two-wire DAC target interface.
// Assumes: 20 MHz system clock, bus clock far slower.
// Notes:   Bit positions refer to the 16-bit input register.
// How it works
// RQ1 - Idle bus lines rest high, only pulled low
// RQ2 - SDA fall with SCL high starts transfer
// RQ3 - Shift seven address bits plus direction bit
// RQ4 - Direction zero writes, one reads
// RQ5 - Address 00011xx selects this device
// RQ6 - Acknowledge low before and through ninth pulse
// RQ7 - Master clocks data per direction bit
// RQ8 - SDA changes only while SCL low
// RQ9 - Acknowledge every received eight-bit block
// RQ10 - Exactly two data bytes per transaction
// RQ11 - Acknowledge second data byte at end
// RQ12 - SDA rise with SCL high stops, idle
// RQ13 - Completed read clears input register
// RQ14 - Power-down input acts asynchronously
// RQ15 - High byte first, MSB first, then load
// RQ16 - Bit15 power-down, bits13-4 code, rest ignored
// RQ17 - Read returns register in write order
// RQ18 - Mismatched address leaves SDA released
// RQ19 - Read drives bits on low, releases ninth
`ifndef DACIF_REGS_SVH
`define DACIF_REGS_SVH
`define DACIF_ADDR_HI5     5'h03
`define DACIF_REG_RST      16'h0000
`define DACIF_PD_BIT       15
`define DACIF_CODE_MSB     13
`define DACIF_CODE_LSB     4
`define DACIF_DATA_BYTES   2
`endif

// >>> core/dacif_pkg.sv
// Purpose: Types for the two-wire DAC target interface.
// Assumes: Nothing beyond the constants header.
// Notes:   One-hot state codes are written out.
package dacif_pkg;
    typedef enum logic [4:0] {
        DACIF_IDLE = 5'b00001,
        DACIF_ADDR = 5'b00010,
        DACIF_WR   = 5'b00100,
        DACIF_RD   = 5'b01000,
        DACIF_IGN  = 5'b10000
    } dacif_state_t;

    typedef struct packed {
        logic       soft_pd;
        logic [9:0] code;
    } dacif_dac_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } dacif_bus_ev_t;
endpackage

// >>> core/dacif_line_sync.sv
// Purpose: Synchronise SCL/SDA and find edges and bus conditions.
// Assumes: Lines come from outside the clock domain.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps
`include "dacif_regs.svh"
module dacif_line_sync (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    // Raw lines
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    // Events
    output dacif_pkg::dacif_bus_ev_t      ev_o
);
    import dacif_pkg::*;
    logic [1:0] scl_s1_q, scl_s1_d;  // scl, sda first stage
    logic [1:0] sync_q, sync_d;      // scl, sda second stage
    logic [1:0] prev_q, prev_d;      // scl, sda one sample back
    always_comb begin
        scl_s1_d = {scl_i, sda_i};
        sync_d   = scl_s1_q;
        prev_d   = sync_q;
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_s1_q <= 2'h3;   // Idle lines high
            sync_q   <= 2'h3;
            prev_q   <= 2'h3;
        end else begin
            scl_s1_q <= scl_s1_d;
            sync_q   <= sync_d;
            prev_q   <= prev_d;
        end
    end
    always_comb begin
        ev_o.scl_rise = sync_q[1] & ~prev_q[1];
        ev_o.scl_fall = ~sync_q[1] & prev_q[1];
        ev_o.start = sync_q[1] & prev_q[1] & ~sync_q[0] & prev_q[0]; // [RQ2]
        ev_o.stop  = sync_q[1] & prev_q[1] & sync_q[0] & ~prev_q[0]; // [RQ12]
        ev_o.sda   = sync_q[0];
    end
endmodule // dacif_line_sync

// >>> core/dacif_top.sv
// Purpose: Two-wire target that loads and reads the DAC input register.
// Assumes: 20 MHz clock; bus clock at most 2.5 MHz (400 ns bits) from the master.
// Notes:   Address match ignores the two low address bits.
`timescale 1ns/100ps
`include "dacif_regs.svh"
module dacif_top (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    // Two-wire bus
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    output logic                      scl_o,
    output logic                      scl_oe_o,
    // Power-down pin and converter side
    input  wire logic                 power_down_input_i,
    output dacif_pkg::dacif_dac_t     dac_o,
    output logic                      dac_on_o,
    output logic [15:0]               input_reg_o
);
    import dacif_pkg::*;

    dacif_bus_ev_t ev;
    dacif_line_sync u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .ev_o      (ev)
    );

    dacif_state_t state_q, state_d;
    logic [3:0]   bit_q, bit_d;     // 0..7 data bits, 8 = ack slot
    logic [7:0]   sh_q, sh_d;
    logic [1:0]   byte_q, byte_d;
    logic         hold_q, hold_d;   // Pull SDA low
    logic [15:0]  ireg_q, ireg_d;
    dacif_dac_t   dac_q, dac_d;
    logic         rd_done_q, rd_done_d;
    logic         lead_q, lead_d;   // Start's own SCL fall pending
    logic         pd_s1_q, pd_s2_q;

    // Converter gating is combinational on the pin, so it acts at once.
    // Synced copy is only for assertions.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
        end else begin
            pd_s1_q <= power_down_input_i;
            pd_s2_q <= pd_s1_q;
        end
    end

    always_comb begin
        state_d   = state_q;
        bit_d     = bit_q;
        sh_d      = sh_q;
        byte_d    = byte_q;
        hold_d    = hold_q;
        ireg_d    = ireg_q;
        dac_d     = dac_q;
        rd_done_d = 1'b0;
        lead_d    = lead_q;
        if (ev.start) begin                                   // [RQ2]
            state_d = DACIF_ADDR;
            lead_d  = 1'b1;
            bit_d   = 4'h0;
            byte_d  = 2'h0;
            hold_d  = 1'b0;
        end else if (ev.stop) begin                           // [RQ12]
            state_d = DACIF_IDLE;
            lead_d  = 1'b0;
            hold_d  = 1'b0;
        end else if (ev.scl_rise && bit_q < 4'h8 &&
                     state_q != DACIF_IDLE) begin
            sh_d = {sh_q[6:0], ev.sda};                       // [RQ3]
        end else if (ev.scl_fall && lead_q) begin
            // Fall that closes the start carries no data bit
            lead_d = 1'b0;
        end else if (ev.scl_fall) begin
            case (state_q)
            DACIF_ADDR: begin
                if (bit_q == 4'h7) begin
                    bit_d = 4'h8;
                    // Ignore low two address bits
                    if (sh_q[7:3] == `DACIF_ADDR_HI5) begin   // [RQ5]
                        hold_d = 1'b1;                        // [RQ6]
                    end else begin
                        state_d = DACIF_IGN;                  // [RQ18]
                    end
                end else if (bit_q == 4'h8) begin
                    bit_d = 4'h0;
                    if (sh_q[0]) begin                        // [RQ4]
                        state_d = DACIF_RD;
                        hold_d  = ~ireg_q[15];                // [RQ19]
                    end else begin
                        state_d = DACIF_WR;
                        hold_d  = 1'b0;
                    end
                end else begin
                    bit_d = bit_q + 4'h1;
                end
            end
            DACIF_WR: begin
                if (bit_q == 4'h7) begin
                    bit_d  = 4'h8;
                    hold_d = 1'b1;                            // [RQ9] [RQ11]
                    if (byte_q == 2'h0) begin
                        ireg_d[15:8] = sh_q;                  // [RQ15]
                    end else if (byte_q == 2'h1) begin
                        ireg_d[7:0] = sh_q;
                        // Low byte lands now, so take the next value
                        dac_d.soft_pd = ireg_d[`DACIF_PD_BIT]; // [RQ16]
                        dac_d.code = ireg_d[`DACIF_CODE_MSB:`DACIF_CODE_LSB];
                    end
                end else if (bit_q == 4'h8) begin
                    bit_d  = 4'h0;
                    hold_d = 1'b0;
                    if (byte_q < 2'(`DACIF_DATA_BYTES)) begin // [RQ10]
                        byte_d = byte_q + 2'h1;
                    end
                end else begin
                    bit_d = bit_q + 4'h1;
                end
            end
            DACIF_RD: begin
                if (bit_q == 4'h7) begin
                    bit_d  = 4'h8;
                    hold_d = 1'b0;                            // [RQ19]
                    if (byte_q == 2'h1) begin
                        rd_done_d = 1'b1;                     // [RQ13]
                    end
                end else if (bit_q == 4'h8) begin
                    bit_d  = 4'h0;
                    if (byte_q < 2'(`DACIF_DATA_BYTES)) begin
                        byte_d = byte_q + 2'h1;
                    end
                    // Next MSB, high byte then low byte
                    hold_d = (byte_q == 2'h0) ? ~ireg_q[7] : 1'b0; // [RQ17]
                end else begin
                    bit_d  = bit_q + 4'h1;
                    // Bytes past the second are left released
                    hold_d = (byte_q < 2'h2) &
                             ~ireg_q[(byte_q == 2'h0 ? 4'hE : 4'h6)
                                     - bit_q[3:0]];           // [RQ8]
                end
            end
            default: ;
            endcase
        end
        if (rd_done_q) begin
            ireg_d = `DACIF_REG_RST;                          // [RQ13]
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q   <= DACIF_IDLE;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            byte_q    <= 2'h0;
            hold_q    <= 1'b0;
            ireg_q    <= `DACIF_REG_RST;
            dac_q     <= '0;
            rd_done_q <= 1'b0;
            lead_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            bit_q     <= bit_d;
            sh_q      <= sh_d;
            byte_q    <= byte_d;
            hold_q    <= hold_d;
            ireg_q    <= ireg_d;
            dac_q     <= dac_d;
            rd_done_q <= rd_done_d;
            lead_q    <= lead_d;
        end
    end

    // Only pull low; released otherwise
    assign sda_o       = 1'b0;                                // [RQ1]
    assign sda_oe_o    = hold_q;
    assign scl_o       = 1'b0;
    assign scl_oe_o    = 1'b0;
    assign dac_o       = dac_q;
    assign input_reg_o = ireg_q;
    // Pin gates output with no clock in the path
    assign dac_on_o = ~dac_q.soft_pd & ~power_down_input_i;   // [RQ14]

    AST_IGN_RELEASED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_q == DACIF_IGN |-> !sda_oe_o) // [RQ18]
        else $error("SDA driven after address mismatch");
    AST_STOP_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ev.stop |=> state_q == DACIF_IDLE && !sda_oe_o) // [RQ12]
        else $error("Stop did not return to idle");
    AST_START_ADDR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ev.start |=> state_q == DACIF_ADDR && bit_q == 4'h0) // [RQ2]
        else $error("Start not taken");
    AST_ACK_HELD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == DACIF_WR && bit_q == 4'h8 && ev.scl_rise)
        |-> sda_oe_o) // [RQ9]
        else $error("No ack on ninth pulse");
    AST_RD_RELEASE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == DACIF_RD && bit_q == 4'h8) |-> !sda_oe_o) // [RQ19]
        else $error("SDA held during read ack slot");
    AST_RD_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_done_q |=> ireg_q == 16'h0000) // [RQ13]
        else $error("Register not cleared after read");
    AST_SDA_STABLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ev.scl_rise ##1 (state_q != DACIF_IDLE && !ev.scl_fall && !ev.stop
        && !ev.start) |-> $stable(sda_oe_o)) // [RQ8]
        else $error("SDA changed while SCL high");
    AST_PD_ASYNC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        power_down_input_i && !pd_s2_q |-> !dac_on_o) // [RQ14]
        else $error("Power-down pin waited for a clock");
    AST_ADDR_ACK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == DACIF_ADDR && bit_q == 4'h8 && ev.scl_rise)
        |-> sda_oe_o) // [RQ6]
        else $error("No ack for own address");
    AST_DAC_LOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_q == DACIF_WR && byte_q == 2'h1 && bit_q == 4'h7 && ev.scl_fall)
        |=> dac_q.code == ireg_q[13:4]) // [RQ16]
        else $error("Converter code not loaded");
    CVR_WRITE: cover property (@(posedge clk_i) state_q == DACIF_WR
        && byte_q == 2'h2);
    CVR_READ: cover property (@(posedge clk_i) rd_done_q);
    CVR_IGN: cover property (@(posedge clk_i) state_q == DACIF_IGN);
    CVR_PD: cover property (@(posedge clk_i) power_down_input_i && !pd_s2_q);
endmodule // dacif_top

// >>> verification/dacif_mst_model.sv
// Purpose: Bus master model that clocks the DAC target.
// Assumes: Open-drain lines with pull-ups in the bench.
// Notes:   SCL stands still high outside frames.
`timescale 1ns/100ps
module dacif_mst_model (
    // Line pulls, high = drive low
    output logic       scl_pull_o,
    output logic       sda_pull_o,
    // Resolved data line
    input  wire logic  sda_i
);
    logic [8:0] got_q;
    event       got_e;

    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end

    // Works from idle and as a repeated start
    task automatic start();
        #100 sda_pull_o = 1'b0;
        #200 scl_pull_o = 1'b0;
        #200 sda_pull_o = 1'b1;
        #200 scl_pull_o = 1'b1;
    endtask

    task automatic stop();
        #100 sda_pull_o = 1'b1;
        #200 scl_pull_o = 1'b0;
        #200 sda_pull_o = 1'b0;
        #400;
    endtask

    // Nine 400 ns bits: low 300 ns leaves room for the target's answer
    task automatic xfer9(input logic [8:0] d);
        for (int i = 8; i >= 0; i--) begin
            #100 sda_pull_o = ~d[i];
            #200 scl_pull_o = 1'b0;
            #50 got_q[i] = sda_i;
            #50 scl_pull_o = 1'b1;
        end
        ->got_e;
    endtask
endmodule // dacif_mst_model

// >>> verification/tb_dac_i2c_slave_interface.sv
// Purpose: Self-checking bench for the DAC two-wire target.
// Assumes: The master model drives every frame.
// Notes:   Expected bus bits queue up before each frame.
`timescale 1ns/100ps
module tb_dac_i2c_slave_interface;
    import dacif_pkg::*;
    logic        clk_i;
    logic        sys_rst_i;
    logic        power_down_input_i;
    logic        scl_pull;
    logic        sda_pull;
    logic        sda_oe_o;
    logic        scl_oe_o;
    logic        dac_on_o;
    dacif_dac_t  dac_o;
    logic [15:0] input_reg_o;
    wire logic   scl_w;
    wire logic   sda_w;
    logic [8:0]  exp_q[$];
    logic [31:0] r;
    int          fail_count;
    int          total_checks;
    int          seed;

    assign scl_w = ~(scl_pull | scl_oe_o);
    assign sda_w = ~(sda_pull | sda_oe_o);

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    dacif_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o), .scl_o(),
        .scl_oe_o(scl_oe_o), .power_down_input_i(power_down_input_i),
        .dac_o(dac_o), .dac_on_o(dac_on_o), .input_reg_o(input_reg_o));

    dacif_mst_model i_mst (.scl_pull_o(scl_pull), .sda_pull_o(sda_pull),
        .sda_i(sda_w));

    task automatic chk_bus(input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH bus exp %h got %h", e, g);
        end
    endtask

    task automatic chk_out(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_dac(input logic [15:0] w);
        chk_out("dac", {5'h00, w[15], w[13:4]}, {5'h00, dac_o});
        chk_out("on", {15'h0, ~(w[15] | power_down_input_i)},
            {15'h0, dac_on_o});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Address, then two data bytes; read bytes are acked then refused
    task automatic frame(input logic [6:0] a, input logic rd,
                         input logic [15:0] d, input logic hit);
        exp_q.push_back({a, rd, ~hit});
        exp_q.push_back({d[15:8], rd ? 1'b0 : ~hit});
        exp_q.push_back({d[7:0], rd | ~hit});
        i_mst.start();
        i_mst.xfer9({a, rd, 1'b1});
        i_mst.xfer9(rd ? 9'h1FE : {d[15:8], 1'b1});
        i_mst.xfer9(rd ? 9'h1FF : {d[7:0], 1'b1});
    endtask

    initial forever begin
        @(i_mst.got_e);
        if (exp_q.size() == 0)
            chk_bus(9'h000, i_mst.got_q);
        else
            chk_bus(exp_q.pop_front(), i_mst.got_q);
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        stop_test();
    end

    initial begin
        seed = 32'hb7db74e7;
        sys_rst_i = 1'b1;
        power_down_input_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #2 sys_rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #2;
        chk_out("reg", 16'h0000, input_reg_o);
        chk_out("oe", 16'h0000, {15'h0, sda_oe_o});
        chk_dac(16'h0000);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            frame({5'h03, i[1:0]}, 1'b0, r[15:0], 1'b1);
            i_mst.stop();
            chk_out("reg", r[15:0], input_reg_o);
            chk_dac(r[15:0]);
            frame({5'h03, ~i[1:0]}, 1'b1, r[15:0], 1'b1);
            i_mst.stop();
            chk_out("reg", 16'h0000, input_reg_o);
        end
        frame(7'h0F, 1'b1, 16'h0000, 1'b1);
        i_mst.stop();
        // Foreign address, then a repeated start without a stop
        frame(7'h4C, 1'b0, r[31:16], 1'b0);
        frame(7'h0D, 1'b0, {1'b1, r[14:0]}, 1'b1);
        i_mst.stop();
        chk_dac({1'b1, r[14:0]});
        frame(7'h0E, 1'b0, {1'b0, r[14:0]}, 1'b1);
        i_mst.stop();
        chk_dac({1'b0, r[14:0]});
        // Pin must act before the next clock edge
        @(posedge clk_i);
        #2 power_down_input_i = 1'b1;
        #1 chk_dac({1'b0, r[14:0]});
        repeat (3) @(posedge clk_i);
        #2 power_down_input_i = 1'b0;
        #1 chk_dac({1'b0, r[14:0]});
        chk_out("oe", 16'h0000, {15'h0, sda_oe_o | scl_oe_o});
        stop_test();
    end
endmodule // tb_dac_i2c_slave_interface
